// [design/psd_pkg.sv]
// shared constants, types and helpers for the pipelined sram cycle decode
package psd_pkg;

  localparam int ADDR_W = 10;
  localparam int MAX_LANES = 8;
  localparam int LANES_DEF = 4;
  localparam int LANE_W = 9;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [1:0] BEAT_RST = 2'h0;
  localparam logic [1:0] START_RST = 2'h0;
  localparam logic [1:0] BEAT_ONE = 2'h1;
  localparam logic SLEEP_RST = 1'b0;
  localparam logic DRIVE_RST = 1'b0;

  typedef enum logic [2:0] {
    ST_DESEL = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } psd_state_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_READ = 2'h1,
    OP_WRITE = 2'h2
  } psd_op_t;

  typedef struct packed {
    psd_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [MAX_LANES-1:0] mask;
  } psd_cmd_t;

  localparam psd_cmd_t CMD_IDLE = '{op: OP_NONE, addr: {ADDR_W{1'b0}}, mask: {MAX_LANES{1'b0}}};

  // low two address bits of a burst beat: interleaved when order is high
  function automatic logic [1:0] psd_burst_addr(input logic [1:0] start, input logic [1:0] beat,
                                                input logic order);
    psd_burst_addr = order ? (start ^ beat) : 2'(start + beat);
  endfunction : psd_burst_addr

endpackage : psd_pkg

// [design/psd_burst.sv]
// two-bit burst address counter, linear or interleaved
`timescale 1ns/1ps
module psd_burst
  import psd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_en,
  input wire logic i_load,
  input wire logic i_step,
  input wire logic [1:0] i_start,
  input wire logic i_order,
  output logic [1:0] o_next
);

  logic [1:0] start_q, start_d;
  logic [1:0] beat_q, beat_d;
  logic order_q, order_d;

  always_comb begin
    start_d = start_q;
    beat_d = beat_q;
    order_d = order_q;
    if (i_load) begin
      start_d = i_start;
      beat_d = BEAT_RST;
      order_d = i_order;
    end else if (i_step) begin
      beat_d = 2'(beat_q + BEAT_ONE);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      start_q <= START_RST;
      beat_q <= BEAT_RST;
      order_q <= 1'b0;
    end else if (i_en) begin
      start_q <= start_d;
      beat_q <= beat_d;
      order_q <= order_d;
    end
  end

  // wraps within four beats since the beat count is two bits wide
  assign o_next = psd_burst_addr(start_q, 2'(beat_q + BEAT_ONE), order_q);

  a_burst_linear:
  assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_en && i_load && !i_order) |=> (o_next == 2'($past(i_start) + BEAT_ONE)))
    else $error("linear burst second beat wrong");

  a_burst_inter:
  assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_en && i_load && i_order) ##1 (i_en && i_step && !i_load)
    |=> (o_next == ($past(i_start, 2) ^ 2'h2)))
    else $error("interleaved burst third beat wrong");

endmodule : psd_burst

// [design/psd_fifo.sv]
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module psd_fifo
  import psd_pkg::*;
#(
  parameter int WIDTH = LANES_DEF * LANE_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign o_in_ready = (cnt_q != FULL_CNT);
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (i_flush) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end else begin
      if (push) begin
        wr_d = (wr_q == LAST_PTR) ? '0 : AW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_d = (rd_q == LAST_PTR) ? '0 : AW'(rd_q + 1'b1);
      end
      if (push && !pop) begin
        cnt_d = (AW + 1)'(cnt_q + 1'b1);
      end else if (pop && !push) begin
        cnt_d = (AW + 1)'(cnt_q - 1'b1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (i_ce) begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_ce && push && !i_flush) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

endmodule : psd_fifo

// [design/psd_sram.sv]
// cycle decode, burst control and data pin control of a pipelined burst sram
`timescale 1ns/1ps
module psd_sram
  import psd_pkg::*;
#(
  parameter int LANES = LANES_DEF
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_cs1_n,
  input wire logic i_cs2,
  input wire logic i_cs3_n,
  input wire logic i_sleep_request,
  input wire logic i_advance_or_load,
  input wire logic i_write_n,
  input wire logic [LANES-1:0] i_byte_lane_select_n,
  input wire logic i_oe_n,
  input wire logic i_clock_gate_low_n,
  input wire logic i_burst_order,
  input wire logic [BYTE_W*LANES-1:0] i_dq,
  input wire logic [LANES-1:0] i_parity_lane_pins,
  output logic [BYTE_W*LANES-1:0] o_dq,
  output logic [LANES-1:0] o_parity_lane_pins,
  output logic [LANES-1:0] o_dq_oe
);

  localparam int WORD_W = LANES * LANE_W;
  localparam int DEPTH = 2 ** ADDR_W;

  // lane storage: parity bit above the data byte
  logic [LANE_W-1:0] mem_q [DEPTH][LANES];

  psd_state_t state_q, state_d;
  psd_cmd_t s1_q, s1_d;
  psd_cmd_t s2_q, s2_d;
  logic [ADDR_W-3:0] hi_q, hi_d;
  logic drive_q, drive_d;
  logic sleep_m_q, sleep_m_d;
  logic sleep_q, sleep_d;
  logic [BYTE_W*LANES-1:0] dq_q, dq_d;
  logic [LANES-1:0] par_q, par_d;

  logic go;
  logic cs_ok;
  logic any_lane;
  logic [MAX_LANES-1:0] lane_mask;
  logic load, step;
  logic [1:0] burst_next;
  logic fifo_in_ready, fifo_out_valid;
  logic push, pop, wr_en;
  logic [WORD_W-1:0] in_word, rd_word, fifo_out;

  assign cs_ok = !i_cs1_n && i_cs2 && !i_cs3_n;
  assign any_lane = !(&i_byte_lane_select_n);
  assign lane_mask = MAX_LANES'(~i_byte_lane_select_n);
  // a full read fifo stalls the pipeline like a gated clock edge
  assign go = i_ce && !i_clock_gate_low_n && fifo_in_ready;
  // a read word enters the fifo on its load edge and leaves on the next enabled edge
  assign push = go && !sleep_q && (s1_d.op == OP_READ);
  assign pop = go && !sleep_q && fifo_out_valid && (s1_q.op == OP_READ);
  assign wr_en = go && !sleep_q && (s2_q.op == OP_WRITE);

  // asynchronous output enable, qualified by the registered read phase
  assign o_dq_oe = {LANES{drive_q && !i_oe_n}};
  assign o_dq = dq_q;
  assign o_parity_lane_pins = par_q;

  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      in_word[l*LANE_W +: LANE_W] = {i_parity_lane_pins[l], i_dq[l*BYTE_W +: BYTE_W]};
    end
  end

  // read of the word being loaded, with bypass for a write landing on the same edge
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      if (wr_en && s2_q.mask[l] && (s2_q.addr == s1_d.addr)) begin
        rd_word[l*LANE_W +: LANE_W] = in_word[l*LANE_W +: LANE_W];
      end else begin
        rd_word[l*LANE_W +: LANE_W] = mem_q[s1_d.addr][l];
      end
    end
  end

  always_comb begin
    sleep_m_d = i_sleep_request;
    sleep_d = sleep_m_q;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sleep_m_q <= SLEEP_RST;
      sleep_q <= SLEEP_RST;
    end else if (i_ce) begin
      sleep_m_q <= sleep_m_d;
      sleep_q <= sleep_d;
    end
  end

  always_comb begin
    state_d = state_q;
    s1_d = s1_q;
    s2_d = s2_q;
    hi_d = hi_q;
    drive_d = drive_q;
    load = 1'b0;
    step = 1'b0;
    if (sleep_q) begin
      state_d = ST_DESEL;
      s1_d = CMD_IDLE;
      s2_d = CMD_IDLE;
      drive_d = 1'b0;
    end else if (go) begin
      s2_d = s1_q;
      // read data leaves the pins before a following write's data phase
      drive_d = (s1_q.op == OP_READ);
      s1_d = CMD_IDLE;
      if (!i_advance_or_load) begin
        if (!cs_ok) begin
          state_d = ST_DESEL;
        end else if (i_write_n) begin
          state_d = ST_READ;
          s1_d.op = OP_READ;
          s1_d.addr = i_addr;
          hi_d = i_addr[ADDR_W-1:2];
          load = 1'b1;
        end else begin
          state_d = ST_WRITE;
          hi_d = i_addr[ADDR_W-1:2];
          load = 1'b1;
          if (any_lane) begin
            s1_d.op = OP_WRITE;
            s1_d.addr = i_addr;
            s1_d.mask = lane_mask;
          end
        end
      end else begin
        unique case (state_q)
          ST_DESEL: begin
            state_d = ST_DESEL;
          end
          ST_READ: begin
            step = 1'b1;
            s1_d.op = OP_READ;
            s1_d.addr = {hi_q, burst_next};
          end
          ST_WRITE: begin
            step = 1'b1;
            if (any_lane) begin
              s1_d.op = OP_WRITE;
              s1_d.addr = {hi_q, burst_next};
              s1_d.mask = lane_mask;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_q <= ST_DESEL;
      s1_q <= CMD_IDLE;
      s2_q <= CMD_IDLE;
      hi_q <= '0;
      drive_q <= DRIVE_RST;
    end else if (i_ce) begin
      state_q <= state_d;
      s1_q <= s1_d;
      s2_q <= s2_d;
      hi_q <= hi_d;
      drive_q <= drive_d;
    end
  end

  always_comb begin
    dq_d = dq_q;
    par_d = par_q;
    if (pop) begin
      // a write landing on the pop edge overrides the stored word
      for (int l = 0; l < LANES; l++) begin
        if (wr_en && s2_q.mask[l] && (s2_q.addr == s1_q.addr)) begin
          dq_d[l*BYTE_W +: BYTE_W] = in_word[l*LANE_W +: BYTE_W];
          par_d[l] = in_word[l*LANE_W + BYTE_W];
        end else begin
          dq_d[l*BYTE_W +: BYTE_W] = fifo_out[l*LANE_W +: BYTE_W];
          par_d[l] = fifo_out[l*LANE_W + BYTE_W];
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      dq_q <= '0;
      par_q <= '0;
    end else if (i_ce) begin
      dq_q <= dq_d;
      par_q <= par_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_ce && wr_en) begin
      for (int l = 0; l < LANES; l++) begin
        if (s2_q.mask[l]) begin
          mem_q[s2_q.addr][l] <= in_word[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  psd_burst u_burst (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_en(go && !sleep_q),
    .i_load(load),
    .i_step(step),
    .i_start(i_addr[1:0]),
    .i_order(i_burst_order),
    .o_next(burst_next)
  );

  psd_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_flush(sleep_q),
    .i_in_valid(push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(rd_word),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(pop),
    .o_out_data(fifo_out)
  );

  a_read_start:
  assert property (@(posedge i_clk) disable iff (!i_rstn)
    (go && !sleep_q && cs_ok && !i_advance_or_load && i_write_n)
    |=> (s1_q.op == OP_READ) && (s1_q.addr == $past(i_addr)))
    else $error("read start not captured");

  a_read_cont:
  assert property (@(posedge i_clk) disable iff (!i_rstn)
    (go && !sleep_q && i_advance_or_load && state_q == ST_READ)
    |=> (s1_q.op == OP_READ) && (state_q == ST_READ))
    else $error("read burst did not continue");

  a_write_start:
  assert property (@(posedge i_clk) disable iff (!i_rstn)
    (go && !sleep_q && cs_ok && !i_advance_or_load && !i_write_n && any_lane)
    |=> (s1_q.op == OP_WRITE) && (s1_q.mask == $past(lane_mask)))
    else $error("write start not captured");

  a_abort_noop:
  assert property (@(posedge i_clk) disable iff (!i_rstn)
    (go && !sleep_q && cs_ok && !i_advance_or_load && !i_write_n && !any_lane)
    |=> (s1_q.op == OP_NONE) ##1 (!$past(go) || s2_q.op == OP_NONE))
    else $error("write abort reached the pipeline");

  a_stall_hold:
  assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && i_clock_gate_low_n && !sleep_q)
    |=> $stable(s1_q) && $stable(s2_q) && $stable(state_q) && $stable(drive_q))
    else $error("gated edge changed state");

  a_write_float:
  assert property (@(posedge i_clk) disable iff (!i_rstn)
    (go && s1_q.op == OP_WRITE) |=> (o_dq_oe == '0))
    else $error("pins driven in write data phase");

  a_oe_mask:
  assert property (@(posedge i_clk) disable iff (!i_rstn)
    (o_dq_oe != '0) |-> (!i_oe_n && s2_q.op == OP_READ))
    else $error("pins driven without output enable");

  a_reset_float:
  assert property (@(posedge i_clk)
    !i_rstn |=> (o_dq_oe == '0) && (state_q == ST_DESEL))
    else $error("not deselected after reset");

  a_read_drive:
  assert property (@(posedge i_clk) disable iff (!i_rstn)
    (go && !sleep_q && s1_q.op == OP_READ) |=> drive_q &&
    ({o_parity_lane_pins[0], o_dq[BYTE_W-1:0]} == mem_q[$past(s1_q.addr)][0]))
    else $error("read data phase not driven");

  a_deselect:
  assert property (@(posedge i_clk) disable iff (!i_rstn)
    (go && !sleep_q && !i_advance_or_load && !cs_ok)
    |=> (state_q == ST_DESEL) && (s1_q.op == OP_NONE))
    else $error("deselect not taken");

  a_sleep_float:
  assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && i_sleep_request) ##1 i_ce |=> sleep_q ##1 (!$past(i_ce) || o_dq_oe == '0))
    else $error("sleep did not float the pins");

  a_write_latch:
  assert property (@(posedge i_clk) disable iff (!i_rstn)
    (go && !sleep_q && s1_q.op == OP_WRITE) ##1 (go && !sleep_q) |-> wr_en)
    else $error("write data not latched on second edge");

endmodule : psd_sram

// [verif/psd_ctrl_model.sv]
// memory controller model driving the synchronous sram bus
`timescale 1ns/1ps
module psd_ctrl_model
  import psd_pkg::*;
#(
  parameter int LANES = LANES_DEF
) (
  output logic o_ce,
  output logic o_gate_n,
  output logic o_adv,
  output logic o_write_n,
  output logic [2:0] o_cs,
  output logic o_order,
  output logic [ADDR_W-1:0] o_addr,
  output logic [LANES-1:0] o_bls_n,
  output logic [LANES*LANE_W-1:0] o_wd
);
  localparam int W = LANES * LANE_W;
  logic [W-1:0] slot [2];
  logic busy [2];
  int mode;

  initial begin
    {o_ce, o_gate_n, o_adv, o_write_n, o_cs, o_order} = 8'hC4;
    o_addr = '0;
    o_bls_n = '1;
    o_wd = '0;
    mode = 0;
    busy = '{1'b0, 1'b0};
    slot = '{'0, '0};
  end

  // kind 0 deselect, 1 read, 2 write, 3 advance; cs is {cs1_n, cs2, cs3_n}
  task automatic issue(input int kind, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] m,
                       input logic ce, input logic gate_n, input logic ord);
    logic [2:0] off;
    off = 3'h2 ^ (3'h1 << ($urandom % 3));
    o_ce = ce;
    o_gate_n = gate_n;
    o_adv = kind == 3;
    o_write_n = kind == 3 ? 1'($urandom) : kind != 2;
    o_cs = kind == 0 ? off : (kind == 3 ? 3'($urandom) : 3'h2);
    o_addr = a;
    o_bls_n = m;
    o_order = ord;
    if (ce && !gate_n) begin
      if (kind < 3) mode = kind;
      // write data goes out for the second enabled edge; otherwise the bus is not held
      o_wd = busy[1] ? slot[1] : ~o_wd;
      busy[1] = busy[0];
      slot[1] = slot[0];
      busy[0] = mode == 2;
      slot[0] = W'({$urandom, $urandom});
    end
  endtask : issue
endmodule : psd_ctrl_model

// [verif/pipelined_sram_cycle_decode_test.sv]
// self-checking bench for the pipelined sram cycle decode
`timescale 1ns/1ps
module pipelined_sram_cycle_decode_test
  import psd_pkg::*;
;
  localparam int LN = 4;
  localparam int DW = LN * LANE_W;
  logic i_clk, i_rstn, i_sleep, i_oe_n, ce, gate_n, adv, wr_n, ord, exp_drv, bord;
  logic [2:0] cs;
  logic [1:0] zz;
  logic [ADDR_W-1:0] addr, base;
  logic [LN-1:0] bls_n, o_par, o_oe;
  logic [LN-1:0] pm [3];
  logic [DW-1:0] wd, exp_q;
  logic [DW-1:0] mem [1 << ADDR_W];
  logic [BYTE_W*LN-1:0] o_dq;
  int pk [3], pa [3];
  int st, beat, fails, num_checks, cyc;

  psd_sram #(.LANES(LN)) dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce), .i_addr(addr), .i_cs1_n(cs[2]), .i_cs2(cs[1]),
    .i_cs3_n(cs[0]), .i_sleep_request(i_sleep), .i_advance_or_load(adv), .i_write_n(wr_n),
    .i_byte_lane_select_n(bls_n), .i_oe_n(i_oe_n), .i_clock_gate_low_n(gate_n),
    .i_burst_order(ord), .i_dq(wd[BYTE_W*LN-1:0]), .i_parity_lane_pins(wd[DW-1 -: LN]),
    .o_dq(o_dq), .o_parity_lane_pins(o_par), .o_dq_oe(o_oe));

  psd_ctrl_model #(.LANES(LN)) ctl (
    .o_ce(ce), .o_gate_n(gate_n), .o_adv(adv), .o_write_n(wr_n), .o_cs(cs), .o_order(ord),
    .o_addr(addr), .o_bls_n(bls_n), .o_wd(wd));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // reference pipeline: a read drives after the next enabled edge, a write lands at the second
  task automatic step();
    logic [1:0] lo;
    if (!i_rstn) begin
      st = 0;
      zz = 2'h0;
      pk = '{0, 0, 0};
      exp_drv = 1'b0;
    end else if (ce && zz[1]) begin
      pk = '{0, 0, 0};
      st = 0;
      exp_drv = 1'b0;
    end else if (ce && !gate_n) begin
      if (!adv) begin
        if (cs != 3'h2) st = 0;
        else begin
          st = wr_n ? 1 : 2;
          base = addr;
          beat = 0;
          bord = ord;
        end
      end else beat = (beat + 1) % 4;
      lo = bord ? base[1:0] ^ 2'(beat) : base[1:0] + 2'(beat);
      for (int i = 2; i > 0; i--) begin
        pk[i] = pk[i-1];
        pa[i] = pa[i-1];
        pm[i] = pm[i-1];
      end
      pk[0] = st;
      pa[0] = int'({base[ADDR_W-1:2], lo});
      pm[0] = bls_n;
      if (pk[2] == 2) begin
        for (int l = 0; l < LN; l++) begin
          if (!pm[2][l]) begin
            mem[pa[2]][BYTE_W*l +: BYTE_W] = wd[BYTE_W*l +: BYTE_W];
            mem[pa[2]][BYTE_W*LN + l] = wd[BYTE_W*LN + l];
          end
        end
      end
      // the read sees a write that lands on its own output edge
      exp_drv = pk[1] == 1;
      if (exp_drv) exp_q = mem[pa[1]];
    end
    if (ce) zz = {zz[0], i_sleep};
  endtask : step

  task automatic go(input int k, input int a, input int m, input int c, input int g,
                    input int o);
    @(posedge i_clk);
    #1;
    step();
    chk("drive", DW'({LN{exp_drv & ~i_oe_n}}), DW'(o_oe));
    if (exp_drv) chk("read data", exp_q, {o_par, o_dq});
    i_oe_n = ~i_oe_n;
    #1;
    chk("async drive", DW'({LN{exp_drv & ~i_oe_n}}), DW'(o_oe));
    #3;
    i_oe_n = ($urandom % 4) == 0;
    ctl.issue(k, ADDR_W'(a), LN'(m), c[0], g[0], o[0]);
  endtask : go

  initial begin
    i_rstn = 1'b0;
    i_sleep = 1'b0;
    i_oe_n = 1'b0;
    {fails, num_checks, cyc, st, beat} = '0;
    zz = 2'h0;
    void'($urandom(52));
    repeat (6) go(0, 0, 15, 1, 0, 0);
    i_rstn = 1'b1;
    // fill every word with four-beat full-lane write bursts
    for (int a = 0; a < (1 << ADDR_W); a += 4) begin
      for (int b = 0; b < 4; b++) go(b ? 3 : 2, a, 0, 1, 0, 0);
    end
    // every lane mask on a load and its inverse on the advance, then read back
    for (int m = 0; m < 16; m++) begin
      go(2, m * 4, m, 1, 0, 0);
      go(3, 0, 15 - m, 1, 0, 0);
      go(1, m * 4, 0, 1, 0, 0);
      go(3, 0, 0, 1, 0, 0);
    end
    // six-beat read bursts from each start in both orders, wrapping
    for (int o = 0; o < 2; o++) begin
      for (int s = 0; s < 4; s++) begin
        for (int b = 0; b < 6; b++) go(b ? 3 : 1, 40 + s, 0, 1, 0, o);
      end
    end
    repeat (3) go(0, 0, 15, 1, 0, 0);
    i_sleep = 1'b1;
    repeat (2) go(0, 0, 15, 1, 0, 0);
    repeat (4) go(1, 8, 0, 1, 0, 0);
    go(0, 0, 15, 1, 0, 0);
    i_sleep = 1'b0;
    repeat (4) go(0, 0, 15, 1, 0, 0);
    // random traffic with clock-enable and clock-gate stalls
    repeat (3000) go($urandom % 4, $urandom, $urandom, $urandom % 8 != 0, $urandom % 6 == 0,
                     $urandom);
    print_verdict();
  end
endmodule : pipelined_sram_cycle_decode_test
